// [rtl/processor_reset_pin_control.sv]
// Reset pin control: pin states during and after external reset.
`timescale 1ns/1ps
`default_nettype none
`include "rst_pin_params.svh"
module processor_reset_pin_control
  import rst_pin_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     nrst_in,
  input  wire logic [`DATA_W-1:0]       core_data_in,
  input  wire logic [`ADDR_W-1:0]       core_addr_in,
  input  wire logic                     core_bus_drive_in,
  input  wire logic                     core_read_nwrite_in,
  input  wire logic                     core_mem_strobe_in,
  input  wire logic                     core_io_strobe_in,
  input  wire logic [`LANES-1:0]        core_bank0_lane_in,
  input  wire logic [`LANES-1:0]        core_bank1_lane_in,
  input  wire logic                     core_flag_in,
  input  wire logic                     core_flag_drive_in,
  input  wire logic                     bus_ready_n_in,
  input  wire logic                     hold_req_n_in,
  output logic                          main_output_clock_out,
  output logic [`DATA_W-1:0]            primary_data_bus_out,
  output logic                          primary_data_bus_oe_n_out,
  output logic [`ADDR_W-1:0]            primary_address_bus_out,
  output logic                          primary_address_bus_oe_n_out,
  output logic                          read_nwrite_out,
  output logic                          io_space_strobe_out,
  output logic                          primary_memory_strobe_out,
  output logic [`LANES-1:0]             bank0_lane_select_out,
  output logic [`LANES-1:0]             bank1_lane_select_out,
  output logic                          flag_out,
  output logic                          flag_oe_n_out,
  output logic                          bus_ready_n_out,
  output logic                          hold_req_n_out,
  output logic                          core_running_out
);
  // ----------------------------------------
  // Reset state
  // ----------------------------------------
  rst_state_t                 state_q;
  logic [`RESET_CNT_W-1:0]    low_cnt_q;
  logic                       main_rise;
  logic                       run;

  main_clock_gen u_clk (
    .mclk_in               (mclk_in),
    .nrst_in               (nrst_in),
    .main_output_clock_out (main_output_clock_out),
    .rise_out              (main_rise)
  );

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (low_cnt_q == `RESET_CNT_W'(`MIN_RESET_CYCLES - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_cnt_q <= '0;
    end else if (state_q == ST_WAIT && main_rise &&
                 low_cnt_q != `RESET_CNT_W'(`MIN_RESET_CYCLES - 1)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  assign run = (state_q == ST_RUN);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_running_out <= 1'b0;
    end else begin
      core_running_out <= run;
    end
  end

  // ----------------------------------------
  // Synchronously reset primary bus
  // ----------------------------------------
  logic sync_rst_q;
  always_ff @(posedge mclk_in) begin
    sync_rst_q <= ~nrst_in;
  end

  always_ff @(posedge mclk_in) begin
    if (sync_rst_q || !nrst_in || !run) begin
      primary_data_bus_out         <= '0;
      primary_data_bus_oe_n_out    <= 1'b1;
      primary_address_bus_out      <= '0;
      primary_address_bus_oe_n_out <= 1'b1;
    end else begin
      primary_data_bus_out         <= core_data_in;
      primary_data_bus_oe_n_out    <= ~core_bus_drive_in;
      primary_address_bus_out      <= core_addr_in;
      primary_address_bus_oe_n_out <= ~core_bus_drive_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in || !run) begin
      read_nwrite_out           <= 1'b1;
      io_space_strobe_out       <= 1'b1;
      primary_memory_strobe_out <= 1'b1;
      bank0_lane_select_out     <= '1;
      bank1_lane_select_out     <= '1;
    end else begin
      read_nwrite_out           <= core_read_nwrite_in;
      io_space_strobe_out       <= core_io_strobe_in;
      primary_memory_strobe_out <= core_mem_strobe_in;
      bank0_lane_select_out     <= core_bank0_lane_in;
      bank1_lane_select_out     <= core_bank1_lane_in;
    end
  end

  // ----------------------------------------
  // Asynchronously reset flag pin
  // ----------------------------------------
  // Immediate float.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_out      <= 1'b0;
      flag_oe_n_out <= 1'b1;
    end else begin
      flag_out      <= core_flag_in;
      flag_oe_n_out <= ~(core_flag_drive_in && run);
    end
  end

  // ----------------------------------------
  // Inputs unaffected by reset
  // ----------------------------------------
  // Plain sampling.
  always_ff @(posedge mclk_in) begin
    bus_ready_n_out <= bus_ready_n_in;
    hold_req_n_out  <= hold_req_n_in;
  end
endmodule
`default_nettype wire

// [rtl/rst_pin_params.svh]
// Constants for the processor reset pin control block.
`ifndef RST_PIN_PARAMS_SVH
`define RST_PIN_PARAMS_SVH
`define CLK_PERIOD_NS      5
`define MAIN_CLK_DIV       2
`define MIN_RESET_CYCLES   10
`define RESET_CNT_W        4
`define DATA_W             32
`define ADDR_W             24
`define LANES              4
`endif

// [rtl/rst_pin_pkg.sv]
// Types for the processor reset pin control block.
package rst_pin_pkg;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b11
  } rst_state_t;
endpackage

// [rtl/main_clock_gen.sv]
// Main output clock divider.
`timescale 1ns/1ps
`default_nettype none
`include "rst_pin_params.svh"
module main_clock_gen (
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  output logic      main_output_clock_out,
  output logic      rise_out
);
  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Main clock generation.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_output_clock_out <= 1'b0;
    end else begin
      main_output_clock_out <= ~main_output_clock_out;
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_out <= 1'b0;
    end else begin
      rise_out <= ~main_output_clock_out;
    end
  end
endmodule
`default_nettype wire

// [tb/rst_pin_sva.sv]
// Checker for the reset pin control block.
`timescale 1ns/1ps
`default_nettype none
`include "rst_pin_params.svh"
module rst_pin_sva (
  input wire logic mclk_in, nrst_in, core_bus_drive_in, core_read_nwrite_in,
  input wire logic bus_ready_n_in, hold_req_n_in, main_output_clock_out,
  input wire logic primary_data_bus_oe_n_out, primary_address_bus_oe_n_out, flag_oe_n_out,
  input wire logic read_nwrite_out, io_space_strobe_out, primary_memory_strobe_out,
  input wire logic bus_ready_n_out, hold_req_n_out, core_running_out,
  input wire logic [`DATA_W-1:0] core_data_in, primary_data_bus_out,
  input wire logic [`ADDR_W-1:0] core_addr_in, primary_address_bus_out,
  input wire logic [`LANES-1:0] core_bank0_lane_in, bank0_lane_select_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  bus_float_a: assert property (!core_running_out |-> primary_address_bus_oe_n_out
    && primary_data_bus_oe_n_out) else $error("bus driven while idle");
  strobe_idle_a: assert property (!core_running_out |-> read_nwrite_out
    && io_space_strobe_out && primary_memory_strobe_out && (&bank0_lane_select_out))
    else $error("strobe active while idle");
  flag_idle_a: assert property (!core_running_out |-> flag_oe_n_out)
    else $error("flag driven while idle");
  bus_follow_a: assert property (core_running_out && core_bus_drive_in |=>
    !primary_address_bus_oe_n_out && primary_address_bus_out == $past(core_addr_in)
    && primary_data_bus_out == $past(core_data_in)) else $error("bus not following");
  strobe_follow_a: assert property (core_running_out |=>
    read_nwrite_out == $past(core_read_nwrite_in)
    && bank0_lane_select_out == $past(core_bank0_lane_in)) else $error("strobe lag");
  clock_toggle_a: assert property ($past(nrst_in) |->
    main_output_clock_out != $past(main_output_clock_out)) else $error("clock stuck");
  input_pass_a: assert property (bus_ready_n_out == $past(bus_ready_n_in)
    && hold_req_n_out == $past(hold_req_n_in)) else $error("ready path changed");
  settle_time_a: assert property ($rose(nrst_in) |-> ##[20:26] core_running_out)
    else $error("settle too long");
endmodule
bind processor_reset_pin_control rst_pin_sva u_rst_pin_sva (.*);
`default_nettype wire

// [tb/reset_source.sv]
// External reset source model.
`timescale 1ns/1ps
`default_nettype none
`include "rst_pin_params.svh"
module reset_source (
  input  wire logic mclk_in,
  input  wire logic req_in,
  output logic      nrst_out
);
  logic [5:0] cnt_q;
  always_ff @(posedge mclk_in or posedge req_in) begin
    if (req_in) begin
      cnt_q <= 6'h00;
    end else if (cnt_q < 6'(`MIN_RESET_CYCLES * `MAIN_CLK_DIV)) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  assign nrst_out = !req_in && (cnt_q == 6'(`MIN_RESET_CYCLES * `MAIN_CLK_DIV));
endmodule
`default_nettype wire

// [tb/test_processor_reset_pin_control.sv]
// Self-checking testbench for the reset pin control block.
`timescale 1ns/1ps
`default_nettype none
`include "rst_pin_params.svh"
module test_processor_reset_pin_control;
  logic mclk_in = 1'b0, req = 1'b1, drv = 1'b0, rdy = 1'b1, rw = 1'b1, nrst_in;
  logic [31:0] dat = 32'h0, d_o;
  logic [23:0] adr = 24'h0, a_o;
  logic [3:0] lan = 4'hF, l0, l1;
  logic mck, d_oe, a_oe, rw_o, io_o, ms_o, fl_oe, rdy_o, run, f_o, hld_o;
  int fails = 0, compares = 0, n;
  always #2.5 mclk_in = ~mclk_in;
  reset_source u_reset_source (.mclk_in(mclk_in), .req_in(req), .nrst_out(nrst_in));
  processor_reset_pin_control u_processor_reset_pin_control (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .core_data_in(dat), .core_addr_in(adr),
    .core_bus_drive_in(drv), .core_read_nwrite_in(rw), .core_mem_strobe_in(rw),
    .core_io_strobe_in(~rw), .core_bank0_lane_in(lan), .core_bank1_lane_in(~lan),
    .core_flag_in(rw), .core_flag_drive_in(drv), .bus_ready_n_in(rdy),
    .hold_req_n_in(~rdy), .main_output_clock_out(mck), .primary_data_bus_out(d_o),
    .primary_data_bus_oe_n_out(d_oe), .primary_address_bus_out(a_o),
    .primary_address_bus_oe_n_out(a_oe), .read_nwrite_out(rw_o), .io_space_strobe_out(io_o),
    .primary_memory_strobe_out(ms_o), .bank0_lane_select_out(l0),
    .bank1_lane_select_out(l1), .flag_out(f_o), .flag_oe_n_out(fl_oe),
    .bus_ready_n_out(rdy_o), .hold_req_n_out(hld_o), .core_running_out(run));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (exp !== got) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic step;
    @(posedge mclk_in) #1;
  endtask
  task automatic test_done;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    n = 0;
    while (run !== 1'b1 && n < 60) begin
      step;
      n++;
      if (run !== 1'b1) chk("idle", 14'h3FFF, {a_oe, d_oe, fl_oe, rw_o, io_o, ms_o, l0, l1});
    end
    if (run !== 1'b1) begin
      fails++;
      test_done;
    end else begin
      chk("settle", 1'b1, n >= 2 * `MIN_RESET_CYCLES);
      $display("reset test end");
    end
  endtask
  task automatic t_follow;
    for (int i = 0; i < 2; i++) begin
      adr = 24'h5A5A5A << i;
      dat = 32'hC33C0FF0 >> i;
      lan = 4'h9 >> i;
      rw = i[0];
      step;
      chk("addr", {1'b0, adr}, {a_oe, a_o});
      chk("data", dat, d_o);
      chk("primary_memory_strobe", {rw, ~rw, rw, lan, ~lan}, {rw_o, io_o, ms_o, l0, l1});
      chk("flag", rw, f_o);
    end
    $display("follow test end");
  endtask
  task automatic t_async;
    step;
    chk("drive", 2'b00, {fl_oe, a_oe});
    req = 1'b1;
    #1;
    chk("async", 2'b10, {fl_oe, a_oe});
    rdy = 1'b0;
    step;
    chk("sync", 1'b1, a_oe);
    chk("ready", 1'b0, rdy_o);
    chk("hold", 1'b1, hld_o);
    req = 1'b0;
    t_reset;
    $display("async test end");
  endtask
  initial begin
    repeat (16) step;
    rw = 1'b0;
    lan = 4'h0;
    drv = 1'b1;
    req = 1'b0;
    t_reset;
    t_follow;
    t_async;
    test_done;
  end
endmodule
`default_nettype wire
